// >>> rtl/gpio_port_map.svh
// register offsets, reset values, pad masks and blink timing for the gpio port
// assumes a 100 MHz core clock and an 8-bit byte address on the register bus
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

`define OFS_DIR 8'h00
`define OFS_OUT 8'h04
`define OFS_PULL 8'h08
`define OFS_FUNC 8'h0c
`define OFS_IN 8'h10
`define OFS_DEV 8'h14
`define OFS_STAT 8'h18

`define RST_DIR 8'h00
`define RST_OUT 8'h00
`define RST_PULL 8'h00
`define RST_FUNC 9'h000
`define RST_DEV 2'h0

`define FUNC_STAT_BIT 8
`define ALT1_MASK 8'hfc
`define SDA_MASK 8'h54
`define SCL_MASK 8'ha8
`define STAT_PAD 7

`define CLK_HZ 100000000
`define OFFLINE_FREQ_MILLIHZ 1000
`define OFFLINE_DUTY_PCT 50
`define ONLINE_FREQ_MILLIHZ 300
`define ONLINE_DUTY_PCT 10
`define SENDING_FREQ_MILLIHZ 10000
`define SENDING_DUTY_PCT 50

`endif

// >>> rtl/gpio_port_pkg.sv
// types shared by the gpio port modules
// assumes nothing of its surroundings
package gpio_port_pkg;
  typedef logic [7:0] pad_vec_t;
  typedef enum logic [3:0] {
    DEV_OFF = 4'b0001,
    DEV_OFFLINE = 4'b0010,
    DEV_ONLINE = 4'b0100,
    DEV_SENDING = 4'b1000
  } dev_state_t;
endpackage

// >>> rtl/pad_ctrl_if.sv
// pad configuration and indicator level shared by the port's own modules
// assumes the top drives the configuration and the blinker drives the lamp
`timescale 1ns/1ps
interface pad_ctrl_if;
  import gpio_port_pkg::*;
  pad_vec_t dir;
  pad_vec_t dout;
  pad_vec_t pull_up;
  pad_vec_t alt1;
  logic stat_sel;
  logic lamp;
  logic sda_o;
  logic sda_oe;
  logic scl_o;
  logic scl_oe;
  modport blink (output lamp);
  modport mux (input dir, dout, pull_up, alt1, stat_sel, lamp, sda_o, sda_oe, scl_o, scl_oe);
endinterface

// >>> rtl/status_blinker.sv
// network status lamp generator: lit/dark phases counted in core clock cycles
// assumes a synchronised active-low reset and a device state that changes on clock edges
`timescale 1ns/1ps
module status_blinker #(
  parameter logic [31:0] OFFLINE_PER = 32'd100,
  parameter logic [31:0] OFFLINE_LIT = 32'd50,
  parameter logic [31:0] ONLINE_PER = 32'd100,
  parameter logic [31:0] ONLINE_LIT = 32'd10,
  parameter logic [31:0] SENDING_PER = 32'd100,
  parameter logic [31:0] SENDING_LIT = 32'd50
) (
  input logic core_clk,
  input logic rst_n,
  input gpio_port_pkg::dev_state_t dev_state,
  pad_ctrl_if.blink pif
);
  import gpio_port_pkg::*;

  dev_state_t prev_r, prev_nxt;
  logic [31:0] cnt_r, cnt_nxt, per_c, lit_c;
  logic lamp_r, lamp_nxt;

  always_comb begin
    case (dev_state)
      DEV_OFFLINE: begin
        per_c = OFFLINE_PER;
        lit_c = OFFLINE_LIT;
      end
      DEV_ONLINE: begin
        per_c = ONLINE_PER;
        lit_c = ONLINE_LIT;
      end
      DEV_SENDING: begin
        per_c = SENDING_PER;
        lit_c = SENDING_LIT;
      end
      default: begin
        per_c = 32'd1;
        lit_c = 32'd0;
      end
    endcase
    prev_nxt = dev_state;
    if (dev_state != prev_r || cnt_r >= per_c - 32'd1) begin
      cnt_nxt = 32'd0;
    end else begin
      cnt_nxt = cnt_r + 32'd1;
    end
    lamp_nxt = (dev_state != DEV_OFF) && (cnt_nxt < lit_c);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= DEV_OFF;
      cnt_r <= 32'd0;
      lamp_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      lamp_r <= lamp_nxt;
    end
  end

  assign pif.lamp = lamp_r;

  a_off_dark: assert property (@(posedge core_clk) disable iff (!rst_n)
    dev_state == DEV_OFF |=> !lamp_r) else $error("lamp lit while off");
  a_offline_duty: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dev_state == DEV_OFFLINE && prev_r == DEV_OFFLINE && $fell(lamp_r))
    |-> cnt_r == OFFLINE_LIT) else $error("offline lit phase wrong");
  a_online_duty: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dev_state == DEV_ONLINE && prev_r == DEV_ONLINE && $fell(lamp_r))
    |-> cnt_r == ONLINE_LIT) else $error("online lit phase wrong");
  a_sending_duty: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dev_state == DEV_SENDING && prev_r == DEV_SENDING && $fell(lamp_r))
    |-> cnt_r == SENDING_LIT) else $error("sending lit phase wrong");
  a_restart_lit: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dev_state != prev_r && dev_state != DEV_OFF) |=> (cnt_r == 32'd0 && lamp_r))
    else $error("state change did not restart lit phase");
  a_period_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dev_state == prev_r && dev_state != DEV_OFF && cnt_r == per_c - 32'd1)
    |=> cnt_r == 32'd0) else $error("blink period length wrong");
endmodule

// >>> rtl/pad_mux.sv
// per-pad selection of general purpose, serial bus and status lamp roles
// assumes a synchronised active-low reset; pad outputs are registered here
`timescale 1ns/1ps
`include "gpio_port_map.svh"
module pad_mux (
  input logic core_clk,
  input logic rst_n,
  pad_ctrl_if.mux pif,
  output gpio_port_pkg::pad_vec_t pad_out,
  output gpio_port_pkg::pad_vec_t pad_oe,
  output gpio_port_pkg::pad_vec_t pad_pull_up
);
  import gpio_port_pkg::*;

  localparam pad_vec_t SDA_M = `SDA_MASK;
  localparam pad_vec_t SCL_M = `SCL_MASK;
  wire [7:0] out_nxt;
  wire [7:0] oe_nxt;
  pad_vec_t out_r, oe_r, pull_r;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pad
      // the lamp role outranks the serial role on the shared pad
      wire stat_c = (i == `STAT_PAD) && pif.stat_sel;
      wire alt_c = pif.alt1[i] && (SDA_M[i] || SCL_M[i]);
      assign out_nxt[i] = stat_c ? ~pif.lamp :
                          alt_c ? (SDA_M[i] ? pif.sda_o : pif.scl_o) :
                          pif.dout[i];
      assign oe_nxt[i] = stat_c ? 1'b1 :
                         alt_c ? (SDA_M[i] ? pif.sda_oe : pif.scl_oe) :
                         pif.dir[i];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= `RST_OUT;
      oe_r <= `RST_DIR;
      pull_r <= `RST_PULL;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      pull_r <= pif.pull_up;
    end
  end

  assign pad_out = out_r;
  assign pad_oe = oe_r;
  assign pad_pull_up = pull_r;

  a_reset_inputs: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (oe_r == 8'h00 && pull_r == 8'h00))
    else $error("pads not input with pull-down after reset");
  a_sda_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    pif.alt1[2] |=> (oe_r[2] == $past(pif.sda_oe) && out_r[2] == $past(pif.sda_o)))
    else $error("sda not routed to pad 3");
  a_scl_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pif.alt1[5] && !pif.stat_sel) |=> oe_r[5] == $past(pif.scl_oe))
    else $error("scl not routed to pad 6");
  a_stat_inverse: assert property (@(posedge core_clk) disable iff (!rst_n)
    pif.stat_sel |=> out_r[7] == !$past(pif.lamp))
    else $error("indicator pad not inverse of lamp");
  a_stat_forced: assert property (@(posedge core_clk) disable iff (!rst_n)
    pif.stat_sel |=> oe_r[7]) else $error("indicator pad not driven");
  a_push_pull: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pif.dir[0] && pif.dout[0]) |=> (oe_r[0] && out_r[0]))
    else $error("output pad does not drive high");
endmodule

// >>> rtl/gpio_port_top.sv
// gpio port with serial bus alternates and a network status lamp, reached over APB
// assumes a 100 MHz core clock, pad inputs synchronous to it, and an
// external serial bus engine driving the sda/scl drive inputs
//
// Summary of operation
// - software picks pull-up or pull-down; reset inputs pull-down
// - pads 3,5,7 offer sda; 4,6,8 offer scl
// - pad 8 second role carries the status lamp
// - output pads drive both levels actively
// - input pads report the level driven externally
// - offline blinks 1 Hz half lit; off dark
// - online blinks 0.3 Hz, lit one tenth
// - sending blinks 10 Hz, half lit
// - lamp pad level is the inverse of lamp
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "gpio_port_map.svh"
module gpio_port_top #(
  parameter logic [31:0] OFFLINE_PERIOD =
    32'(64'(`CLK_HZ) * 64'd1000 / 64'(`OFFLINE_FREQ_MILLIHZ)),
  parameter logic [31:0] ONLINE_PERIOD =
    32'(64'(`CLK_HZ) * 64'd1000 / 64'(`ONLINE_FREQ_MILLIHZ)),
  parameter logic [31:0] SENDING_PERIOD =
    32'(64'(`CLK_HZ) * 64'd1000 / 64'(`SENDING_FREQ_MILLIHZ))
) (
  input logic core_clk,
  input logic reset_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input gpio_port_pkg::pad_vec_t pad_in,
  output gpio_port_pkg::pad_vec_t pad_out,
  output gpio_port_pkg::pad_vec_t pad_oe,
  output gpio_port_pkg::pad_vec_t pad_pull_up,
  input logic sda_drive_o,
  input logic sda_drive_oe,
  input logic scl_drive_o,
  input logic scl_drive_oe,
  output logic sda_in,
  output logic scl_in
);
  import gpio_port_pkg::*;

  localparam logic [31:0] OFFLINE_LIT =
    32'(64'(OFFLINE_PERIOD) * 64'(`OFFLINE_DUTY_PCT) / 64'd100);
  localparam logic [31:0] ONLINE_LIT =
    32'(64'(ONLINE_PERIOD) * 64'(`ONLINE_DUTY_PCT) / 64'd100);
  localparam logic [31:0] SENDING_LIT =
    32'(64'(SENDING_PERIOD) * 64'(`SENDING_DUTY_PCT) / 64'd100);
  localparam pad_vec_t SDA_M = `SDA_MASK;
  localparam pad_vec_t SCL_M = `SCL_MASK;

  // reset release through two flip-flops
  logic rst_meta_r, rst_n_s;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  // register file state
  pad_vec_t dir_r, dir_nxt;
  pad_vec_t dout_r, dout_nxt;
  pad_vec_t pull_r, pull_nxt;
  logic [8:0] func_r, func_nxt;
  logic [1:0] dev_r, dev_nxt;
  pad_vec_t in_r, in_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic sda_in_r, sda_in_nxt;
  logic scl_in_r, scl_in_nxt;

  logic setup_c, access_c, hit_c;
  logic [31:0] rdata_c;
  dev_state_t dev_state_c;

  pad_ctrl_if pif ();

  // decode of the bus phases
  always_comb begin
    setup_c = psel && !penable;
    access_c = psel && penable && pready_r;
    hit_c = 1'b1;
    rdata_c = 32'h0000_0000;
    case (paddr)
      `OFS_DIR: rdata_c = {24'h00_0000, dir_r};
      `OFS_OUT: rdata_c = {24'h00_0000, dout_r};
      `OFS_PULL: rdata_c = {24'h00_0000, pull_r};
      `OFS_FUNC: rdata_c = {23'h00_0000, func_r};
      `OFS_IN: rdata_c = {24'h00_0000, in_r};
      `OFS_DEV: rdata_c = {30'h0000_0000, dev_r};
      `OFS_STAT: rdata_c = {31'h0000_0000, pif.lamp};
      default: hit_c = 1'b0;
    endcase
  end

  // register next values
  always_comb begin
    dir_nxt = dir_r;
    dout_nxt = dout_r;
    pull_nxt = pull_r;
    func_nxt = func_r;
    dev_nxt = dev_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = setup_c;
    in_nxt = pad_in;
    sda_in_nxt = &(pad_in | ~(func_r[7:0] & SDA_M));
    scl_in_nxt = &(pad_in | ~(func_r[7:0] & SCL_M));
    if (setup_c) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : rdata_c;
      pslverr_nxt = !hit_c;
    end
    if (access_c && pwrite) begin
      case (paddr)
        `OFS_DIR: dir_nxt = pwdata[7:0];
        `OFS_OUT: dout_nxt = pwdata[7:0];
        `OFS_PULL: pull_nxt = pwdata[7:0];
        `OFS_FUNC: func_nxt = {pwdata[`FUNC_STAT_BIT], pwdata[7:0] & `ALT1_MASK};
        `OFS_DEV: dev_nxt = pwdata[1:0];
        default: dev_nxt = dev_r;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dir_r <= `RST_DIR;
      dout_r <= `RST_OUT;
      pull_r <= `RST_PULL;
      func_r <= `RST_FUNC;
      dev_r <= `RST_DEV;
      in_r <= 8'h00;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      sda_in_r <= 1'b1;
      scl_in_r <= 1'b1;
    end else begin
      dir_r <= dir_nxt;
      dout_r <= dout_nxt;
      pull_r <= pull_nxt;
      func_r <= func_nxt;
      dev_r <= dev_nxt;
      in_r <= in_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      sda_in_r <= sda_in_nxt;
      scl_in_r <= scl_in_nxt;
    end
  end

  // device state code to one-hot state
  always_comb begin
    case (dev_r)
      2'h1: dev_state_c = DEV_OFFLINE;
      2'h2: dev_state_c = DEV_ONLINE;
      2'h3: dev_state_c = DEV_SENDING;
      default: dev_state_c = DEV_OFF;
    endcase
  end

  assign pif.dir = dir_r;
  assign pif.dout = dout_r;
  assign pif.pull_up = pull_r;
  assign pif.alt1 = func_r[7:0];
  assign pif.stat_sel = func_r[`FUNC_STAT_BIT];
  assign pif.sda_o = sda_drive_o;
  assign pif.sda_oe = sda_drive_oe;
  assign pif.scl_o = scl_drive_o;
  assign pif.scl_oe = scl_drive_oe;

  status_blinker #(
    .OFFLINE_PER(OFFLINE_PERIOD),
    .OFFLINE_LIT(OFFLINE_LIT),
    .ONLINE_PER(ONLINE_PERIOD),
    .ONLINE_LIT(ONLINE_LIT),
    .SENDING_PER(SENDING_PERIOD),
    .SENDING_LIT(SENDING_LIT)
  ) u_blink (
    .core_clk(core_clk),
    .rst_n(rst_n_s),
    .dev_state(dev_state_c),
    .pif(pif.blink)
  );

  pad_mux u_mux (
    .core_clk(core_clk),
    .rst_n(rst_n_s),
    .pif(pif.mux),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sda_in = sda_in_r;
  assign scl_in = scl_in_r;

  // bus phase sequences
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready_r && psel && penable;
  endsequence

  sequence s_write_pull;
    psel && penable && pready_r && pwrite && paddr == `OFS_PULL;
  endsequence

  sequence s_write_func;
    psel && penable && pready_r && pwrite && paddr == `OFS_FUNC;
  endsequence

  a_apb_answer: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    s_setup |=> pready_r) else $error("no answer in first access cycle");
  a_apb_release: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    s_answer |=> !pready_r) else $error("ready held past the access edge");
  a_pull_write: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    s_write_pull |=> ##1 pad_pull_up == $past(pwdata[7:0], 2))
    else $error("pull selection not applied to pads");
  a_func_write: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    s_write_func |=> func_r == {$past(pwdata[8]), $past(pwdata[7:0]) & `ALT1_MASK})
    else $error("function select not stored");
  a_input_sample: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    1'b1 |=> in_r == $past(pad_in)) else $error("input level not sampled");
  a_input_read: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    (psel && !penable && !pwrite && paddr == `OFS_IN)
    |=> prdata_r == {24'h00_0000, $past(in_r)})
    else $error("input read returns wrong level");
  a_lamp_pad: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    (pif.stat_sel && $past(pif.stat_sel)) |-> ##1 pad_out[7] == !$past(pif.lamp))
    else $error("lamp pad level not inverse");
  a_off_pad_high: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    (dev_r == 2'h0 && pif.stat_sel) [*3] |-> pad_out[7] && pad_oe[7])
    else $error("switched off lamp pad not dark");
  a_unmapped_err: assert property (@(posedge core_clk) disable iff (!rst_n_s)
    (psel && !penable && paddr > `OFS_STAT) |=> pslverr_r && pready_r)
    else $error("unmapped address not refused");
endmodule

// >>> verification/pad_world.sv
// far side of the pads: external devices, pull resistors and the lamp transistor
// assumes external drivers are only enabled on pads the port is not driving
`timescale 1ns/1ps
module pad_world (
  input gpio_port_pkg::pad_vec_t pad_out,
  input gpio_port_pkg::pad_vec_t pad_oe,
  input gpio_port_pkg::pad_vec_t pad_pull_up,
  input gpio_port_pkg::pad_vec_t ext_drv,
  input gpio_port_pkg::pad_vec_t ext_en,
  output gpio_port_pkg::pad_vec_t wire_lvl,
  output logic lamp_lit
);
  import gpio_port_pkg::*;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        wire_lvl[i] = pad_out[i];
      end else if (ext_en[i]) begin
        wire_lvl[i] = ext_drv[i];
      end else begin
        wire_lvl[i] = pad_pull_up[i];
      end
    end
  end
  // the transistor lights the lamp while the pad is low
  assign lamp_lit = ~wire_lvl[7];
endmodule

// >>> verification/gpio_port_with_status_blinker_bench.sv
// self-checking bench for the gpio port: register model, pad checks and lamp timing
// assumes pad_world as the far side and short blink periods set by parameter
`timescale 1ns/1ps
`include "gpio_port_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module gpio_port_with_status_blinker_bench;
  import gpio_port_pkg::*;
  localparam int PER [4] = '{0, 20, 30, 10};
  localparam int DUTY [4] = '{0, `OFFLINE_DUTY_PCT, `ONLINE_DUTY_PCT, `SENDING_DUTY_PCT};
  logic core_clk = 0;
  logic reset_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sda_in, scl_in, lamp_lit, er;
  logic sda_o = 0;
  logic sda_oe = 0;
  logic scl_o = 0;
  logic scl_oe = 0;
  pad_vec_t pad_in, pad_out, pad_oe, pad_pull_up, oe_x, out_x, wire_x;
  pad_vec_t ext_drv = 8'h00;
  pad_vec_t ext_en = 8'h00;
  int err_count = 0;
  int comparisons = 0;
  int dir_m, out_m, pull_m, func_m, n;
  logic [7:0] ofs [5] = '{`OFS_DIR, `OFS_OUT, `OFS_PULL, `OFS_FUNC, `OFS_DEV};
  int dev_seq [4] = '{1, 2, 3, 1};

  always #5 core_clk = ~core_clk;

  gpio_port_top #(.OFFLINE_PERIOD(32'(PER[1])), .ONLINE_PERIOD(32'(PER[2])),
    .SENDING_PERIOD(32'(PER[3]))) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .sda_drive_o(sda_o), .sda_drive_oe(sda_oe),
    .scl_drive_o(scl_o), .scl_drive_oe(scl_oe), .sda_in(sda_in), .scl_in(scl_in));

  pad_world i_world (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .ext_drv(ext_drv), .ext_en(ext_en), .wire_lvl(pad_in), .lamp_lit(lamp_lit));

  task automatic complete_run();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected pad drive and wire level from the register model
  task automatic expect_pads();
    for (int i = 0; i < 8; i++) begin
      oe_x[i] = dir_m[i];
      out_x[i] = out_m[i];
      if (i >= 2 && func_m[i]) begin
        oe_x[i] = (i % 2 == 0) ? sda_oe : scl_oe;
        out_x[i] = (i % 2 == 0) ? sda_o : scl_o;
      end
      if (i == 7 && func_m[8]) begin
        oe_x[i] = 1'b1;
        out_x[i] = 1'b1;
      end
      wire_x[i] = oe_x[i] ? out_x[i] : (ext_en[i] ? ext_drv[i] : pull_m[i]);
    end
  endtask

  task automatic measure(input int k);
    int lit;
    lit = PER[k] * DUTY[k] / 100;
    // the restarted lit phase reaches the pad two edges after the state write
    repeat (3) @(posedge core_clk);
    `CHK(lamp_lit, 1'b1)
    `CHK(pad_oe[7], 1'b1)
    n = 0;
    while (lamp_lit === 1'b1 && n < 100) begin
      n++;
      @(posedge core_clk);
    end
    `CHK(n, lit)
    n = 0;
    while (lamp_lit === 1'b0 && n < 100) begin
      n++;
      @(posedge core_clk);
    end
    `CHK(n, PER[k] - lit)
  endtask

  initial begin
    void'($urandom(32'h53ab));
    repeat (12) @(posedge core_clk);
    `CHK(pad_oe, 8'h00)
    `CHK(pad_pull_up, 8'h00)
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (ofs[j]) begin
      apb(ofs[j], 1'b0, 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(8'h1c, 1'b1, 32'h1);
    `CHK(er, 1'b1)
    apb(8'h1c, 1'b0, 32'h0);
    `CHK(er, 1'b1)
    for (int r = 0; r < 6; r++) begin
      dir_m = $urandom & 32'hff;
      out_m = $urandom & 32'hff;
      pull_m = $urandom & 32'hff;
      func_m = (r == 0) ? 0 : ($urandom & 32'h1fc);
      sda_o <= 1'($urandom);
      sda_oe <= 1'($urandom);
      scl_o <= 1'($urandom);
      scl_oe <= 1'($urandom);
      apb(`OFS_DIR, 1'b1, 32'(dir_m));
      apb(`OFS_OUT, 1'b1, 32'(out_m));
      apb(`OFS_PULL, 1'b1, 32'(pull_m));
      apb(`OFS_FUNC, 1'b1, 32'(func_m) | 32'h3);
      expect_pads();
      ext_drv <= 8'($urandom);
      ext_en <= ~oe_x;
      repeat (4) @(posedge core_clk);
      expect_pads();
      `CHK(pad_oe, oe_x)
      `CHK(pad_out, out_x)
      `CHK(pad_pull_up, 8'(pull_m))
      `CHK(sda_in, &(wire_x | ~(8'(func_m) & `SDA_MASK)))
      `CHK(scl_in, &(wire_x | ~(8'(func_m) & `SCL_MASK)))
      apb(`OFS_IN, 1'b0, 32'h0);
      `CHK(rd, {24'h0, wire_x})
      apb(`OFS_FUNC, 1'b0, 32'h0);
      `CHK(rd, 32'(func_m))
    end
    dir_m = 0;
    func_m = 32'h100;
    apb(`OFS_DIR, 1'b1, 32'h0);
    apb(`OFS_FUNC, 1'b1, 32'h100);
    foreach (dev_seq[j]) begin
      apb(`OFS_DEV, 1'b1, 32'(dev_seq[j]));
      measure(dev_seq[j]);
      // move into the dark phase so the next change must restart the period
      repeat (PER[dev_seq[j]] * DUTY[dev_seq[j]] / 100 + 2) @(posedge core_clk);
    end
    apb(`OFS_DEV, 1'b1, 32'h0);
    repeat (3) @(posedge core_clk);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      if (lamp_lit !== 1'b0) n++;
    end
    `CHK(n, 0)
    complete_run();
  end
endmodule
